// ### rtl/erd_cfg.svh
// Register offsets, bit positions, descriptor layout and reset values
`ifndef ERD_CFG_SVH
`define ERD_CFG_SVH
// ==========================================
// Register byte offsets
`define ERD_A_OPM 5'h00
`define ERD_A_STS 5'h04
`define ERD_A_BASE 5'h08
`define ERD_A_POLL 5'h0C
`define ERD_A_MISS 5'h10
`define ERD_A_THR 5'h14
`define ERD_A_CUR 5'h18
// ==========================================
// Register bit positions
`define ERD_B_START 1
`define ERD_B_TSEN 2
`define ERD_B_DFLUSH 24
`define ERD_B_RXI 6
`define ERD_B_RBU 7
// ==========================================
// Descriptor layout, word size and threshold reset value
`define ERD_D_OWN 31
`define ERD_D_DERR 14
`define ERD_D_FS 9
`define ERD_D_LS 8
`define ERD_D_SZH 12
`define ERD_D_CHAIN 14
`define ERD_D_EOR 15
`define ERD_W1 32'h0000_0004
`define ERD_W2 32'h0000_0008
`define ERD_W3 32'h0000_000C
`define ERD_DSTEP 32'h0000_0010
`define ERD_WORD 3'h4
`define ERD_THR_RST 12'h040
`endif

// ### rtl/erd_pkg.sv
// Types of the receive descriptor engine
package erd_pkg;
	typedef enum logic [3:0] {ST_IDLE, ST_RD0, ST_RD1, ST_RD2, ST_RD3, ST_WAIT, ST_XFER,
		ST_PEEK, ST_TS2, ST_TS3, ST_CLOSE, ST_SUSP, ST_DROP} erd_state_t;
	typedef struct packed {
		erd_state_t st;
		logic [31:0] cur;
		logic [31:0] nxt_d;
		logic [31:0] w0;
		logic [12:0] size;
		logic chain;
		logic eor;
		logic [31:0] bufa;
		logic [12:0] off;
		logic [13:0] flen;
		logic mid;
		logic fs;
		logic eof_seen;
		logic [2:0] lastb;
		logic cur_eof;
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic pop;
		logic drop;
		logic [15:0] miss;
		logic ev_rxi;
		logic ev_rbu;
		logic by_frame;
		logic sof_d;
	} erd_core_t;
	typedef struct packed {
		logic start;
		logic tsen;
		logic dflush;
		logic rxi;
		logic rbu;
		logic [31:0] base;
		logic [11:0] thr;
		logic poll;
		logic ack;
		logic [31:0] dat;
	} erd_regs_t;
endpackage

// ### rtl/erd_ctl_if.sv
// Control and status link between the register file and the engine
interface erd_ctl_if;
	logic start;
	logic tsen;
	logic dflush;
	logic [31:0] base;
	logic [11:0] thr;
	logic poll;
	logic ev_rxi;
	logic ev_rbu;
	logic [15:0] miss;
	logic [31:0] cur;
	modport regs (output start, tsen, dflush, base, thr, poll, input ev_rxi, ev_rbu, miss, cur);
	modport core (input start, tsen, dflush, base, thr, poll, output ev_rxi, ev_rbu, miss, cur);
endinterface

// ### rtl/erd_regs.sv
// Wishbone register file of the receive descriptor engine
`include "erd_cfg.svh"
module erd_regs
	import erd_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [4:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	erd_ctl_if.regs ctl
);
	erd_regs_t q_r, q_nxt;
	logic acc;
	logic [31:0] wv;
	logic [31:0] clr;
	logic [31:0] tw;

	function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	always_comb
	begin
		q_nxt = q_r;
		acc = i_wb_cyc && i_wb_stb;
		q_nxt.ack = acc && !q_r.ack;
		q_nxt.poll = 1'b0;
		wv = wmask({7'h00, q_r.dflush, 21'h000000, q_r.tsen, q_r.start, 1'b0}, i_wb_dat, i_wb_sel);
		tw = wmask({20'h00000, q_r.thr}, i_wb_dat, i_wb_sel);
		clr = 32'h0000_0000;
		if (acc && q_r.ack && i_wb_we)
		begin
			case (i_wb_adr)
				`ERD_A_OPM:
				begin
					q_nxt.start = wv[`ERD_B_START];
					q_nxt.tsen = wv[`ERD_B_TSEN];
					q_nxt.dflush = wv[`ERD_B_DFLUSH];
				end
				`ERD_A_STS: clr = wmask(32'h0000_0000, i_wb_dat, i_wb_sel);
				`ERD_A_BASE: q_nxt.base = wmask(q_r.base, i_wb_dat, i_wb_sel);
				`ERD_A_POLL: q_nxt.poll = 1'b1;
				`ERD_A_THR: q_nxt.thr = tw[11:0];
				default: ;
			endcase
		end
		// Hardware set wins over a write-one clear
		q_nxt.rxi = ctl.ev_rxi || (q_r.rxi && !clr[`ERD_B_RXI]);
		q_nxt.rbu = ctl.ev_rbu || (q_r.rbu && !clr[`ERD_B_RBU]);
		if (acc && !q_r.ack && !i_wb_we)
		begin
			case (i_wb_adr)
				`ERD_A_OPM: q_nxt.dat = {7'h00, q_r.dflush, 21'h000000, q_r.tsen, q_r.start, 1'b0};
				`ERD_A_STS: q_nxt.dat = {24'h000000, q_r.rbu, q_r.rxi, 6'h00};
				`ERD_A_BASE: q_nxt.dat = q_r.base;
				`ERD_A_MISS: q_nxt.dat = {16'h0000, ctl.miss};
				`ERD_A_THR: q_nxt.dat = {20'h00000, q_r.thr};
				`ERD_A_CUR: q_nxt.dat = ctl.cur;
				default: q_nxt.dat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			q_r <= '{thr: `ERD_THR_RST, default: '0};
		else
			q_r <= q_nxt;
	end

	assign o_wb_dat = q_r.dat;
	assign o_wb_ack = q_r.ack;
	assign ctl.start = q_r.start;
	assign ctl.tsen = q_r.tsen;
	assign ctl.dflush = q_r.dflush;
	assign ctl.base = q_r.base;
	assign ctl.thr = q_r.thr;
	assign ctl.poll = q_r.poll;

	property p_ack;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_wb_cyc && i_wb_stb && !q_r.ack) |=> q_r.ack ##1 !q_r.ack;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not a single cycle pulse");
endmodule

// ### rtl/erd_tx_word3.sv
// Fourth transmit descriptor word: pointer decode and stamp write-back
`include "erd_cfg.svh"
module erd_tx_word3
	import erd_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_own,
	input wire logic i_chain,
	input wire logic [31:0] i_word3,
	input wire logic i_done,
	input wire logic i_stamp_req,
	input wire logic i_last,
	input wire logic [31:0] i_stamp_hi,
	output logic [31:0] o_buf2,
	output logic [31:0] o_next,
	output logic o_wr,
	output logic [31:0] o_data
);
	logic [31:0] buf2_r, next_r, data_r;
	logic wr_r;

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			buf2_r <= 32'h0000_0000;
			next_r <= 32'h0000_0000;
			wr_r <= 1'b0;
			data_r <= 32'h0000_0000;
		end
		else
		begin
			if (i_own && !i_chain)
				buf2_r <= i_word3; // R1
			if (i_own && i_chain)
				next_r <= i_word3; // R1
			wr_r <= i_done && i_stamp_req && i_last; // R2
			if (i_done && i_stamp_req && i_last)
				data_r <= i_stamp_hi; // R2
		end
	end

	assign o_buf2 = buf2_r;
	assign o_next = next_r;
	assign o_wr = wr_r;
	assign o_data = data_r;

	property p_stamp;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_done && i_stamp_req && i_last) |=> (o_wr && o_data == $past(i_stamp_hi));
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp high not written back"); // R2
	property p_nostamp;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!(i_done && i_stamp_req && i_last) |=> !o_wr;
	endproperty
	a_nostamp: assert property (p_nostamp) else $error("stamp written without request"); // R2
	property p_ptr;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_own && i_chain) |=> o_next == $past(i_word3);
	endproperty
	a_ptr: assert property (p_ptr) else $error("next pointer not taken"); // R1
endmodule

// ### rtl/erd_top.sv
// Receive descriptor DMA engine with transmit word3 helper
// Function
// [R1] Owned tx word3 is buffer-2 address in ring, next descriptor when chained.
// [R2] Write stamp high to tx word3 only when stamping requested and last segment.
// [R3] Software prepares four words and sets ownership before handing descriptors over.
// [R4] Setting receive start enters run and starts fetching descriptors.
// [R5] A CPU-owned fetched descriptor sends the engine to suspend.
// [R6] Copy FIFO data into the buffer; on full or frame end fetch next.
// [R7] Next CPU-owned mid-frame with flushing: descriptor error and last segment set.
// [R8] Next DMA-owned mid-frame: close current as intermediate, continue in next buffer.
// [R9] With stamping on, write stamp to words two, three, then closing status.
// [R10] After close: continue if next owned, else suspend, buffer unavailable, flush.
// [R11] Leave suspend on poll demand or new frame start, then fetch.
// [R12] Acquire descriptors on run entry, buffer full, frame end, frame, poll.
// [R13] Start moving a frame only once FIFO level reaches the threshold; the code also starts when a whole frame is in the FIFO.
// [R14] First buffer of a frame marked first segment; single buffer gets both.
// [R15] Clear ownership when the buffer fills or the frame ends.
// [R16] At frame end: fetch next, close previous with last segment, then interrupt.
// [R17] Set buffer unavailable before entering suspend on a CPU-owned descriptor.
// [R18] Suspend keeps the descriptor pointer and resumes from it.
// [R19] New frame while suspended refetches current descriptor, runs if now owned.
// [R20] Still CPU-owned: discard head frame, count it missed, repeat per frame.
// [R21] With disable-flush set: no discard, flag unavailable, back to suspend.
// [R22] A descriptor is four consecutive 32-bit words.
// [R23] Ownership bit one means DMA, zero means CPU.
// [R24] Word zero length field holds final or accumulated transferred byte count.
// [R25] Ownership read with whole word zero; CPU-owned descriptors never written.
//
// Local design decisions: the Wishbone register port and the register addresses.
`include "erd_cfg.svh"
module erd_top
	import erd_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [4:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [31:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_rdata,
	input wire logic [11:0] i_fifo_level,
	input wire logic [7:0] i_fifo_frames,
	input wire logic i_fifo_valid,
	input wire logic [31:0] i_fifo_data,
	input wire logic i_fifo_sof,
	input wire logic i_fifo_eof,
	input wire logic [2:0] i_fifo_bytes,
	output logic o_fifo_pop,
	output logic o_fifo_drop,
	input wire logic [63:0] i_rx_stamp,
	input wire logic i_tx_own,
	input wire logic i_tx_chain,
	input wire logic [31:0] i_tx_word3,
	input wire logic i_tx_done,
	input wire logic i_tx_stamp_req,
	input wire logic i_tx_last,
	input wire logic [31:0] i_tx_stamp_hi,
	output logic [31:0] o_tx_buf2_addr,
	output logic [31:0] o_tx_next_desc,
	output logic o_tx_w3_wr,
	output logic [31:0] o_tx_w3_data
);
	erd_core_t q_r, q_nxt;
	erd_ctl_if ctl ();
	logic ack;
	logic sof_new;
	logic [2:0] inc;
	logic [12:0] off_n;

	// ==========================================
	// Register file and transmit helper
	erd_regs u_regs (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr),
		.i_wb_dat(i_wb_dat),
		.i_wb_sel(i_wb_sel),
		.o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack),
		.ctl(ctl.regs)
	);

	erd_tx_word3 u_tx3 (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_own(i_tx_own),
		.i_chain(i_tx_chain),
		.i_word3(i_tx_word3),
		.i_done(i_tx_done),
		.i_stamp_req(i_tx_stamp_req),
		.i_last(i_tx_last),
		.i_stamp_hi(i_tx_stamp_hi),
		.o_buf2(o_tx_buf2_addr),
		.o_next(o_tx_next_desc),
		.o_wr(o_tx_w3_wr),
		.o_data(o_tx_w3_data)
	);

	// ==========================================
	// Helpers
	function automatic erd_core_t issue(input erd_core_t s, input logic we, input logic [31:0] a,
		input logic [31:0] d);
		erd_core_t r;
		r = s;
		r.req = 1'b1;
		r.we = we;
		r.addr = a;
		r.wdata = d;
		return r;
	endfunction

	function automatic logic [31:0] desc_next(input logic [31:0] cur, input logic ch, input logic eor,
		input logic [31:0] w3, input logic [31:0] base);
		if (ch)
			return w3;
		else if (eor)
			return base;
		else
			return cur + `ERD_DSTEP; // R22
	endfunction

	function automatic logic [31:0] close_word(input logic [13:0] fl, input logic fs, input logic ls,
		input logic err);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[29:16] = fl; // R24
		w[`ERD_D_DERR] = err;
		w[`ERD_D_FS] = fs;
		w[`ERD_D_LS] = ls;
		w[`ERD_D_OWN] = 1'b0;
		return w;
	endfunction

	// ==========================================
	// Descriptor engine
	always_comb
	begin
		q_nxt = q_r;
		ack = q_r.req && i_mem_ack;
		sof_new = i_fifo_sof && !q_r.sof_d;
		inc = i_fifo_eof ? i_fifo_bytes : `ERD_WORD;
		off_n = q_r.off + 13'(q_r.lastb);
		q_nxt.pop = 1'b0;
		q_nxt.drop = 1'b0;
		q_nxt.ev_rxi = 1'b0;
		q_nxt.ev_rbu = 1'b0;
		q_nxt.sof_d = i_fifo_sof;
		if (ack)
			q_nxt.req = 1'b0;
		case (q_r.st)
			ST_IDLE:
			begin
				if (ctl.start)
				begin
					q_nxt.cur = ctl.base; // R4
					q_nxt = issue(q_nxt, 1'b0, ctl.base, 32'h0000_0000); // R12
					q_nxt.by_frame = 1'b0;
					q_nxt.st = ST_RD0;
				end
			end
			ST_RD0:
			begin
				if (ack)
				begin
					if (i_mem_rdata[`ERD_D_OWN]) // R23 R25
					begin
						q_nxt = issue(q_nxt, 1'b0, q_r.cur + `ERD_W1, 32'h0000_0000);
						q_nxt.st = ST_RD1; // R19
					end
					else if (q_r.by_frame && !ctl.dflush)
					begin
						q_nxt.drop = 1'b1; // R20
						q_nxt.miss = q_r.miss + 16'h0001; // R20
						q_nxt.st = ST_DROP;
					end
					else
					begin
						q_nxt.ev_rbu = 1'b1; // R17 R21
						q_nxt.st = ST_SUSP; // R5
					end
				end
			end
			ST_RD1:
			begin
				if (ack)
				begin
					q_nxt.size = i_mem_rdata[`ERD_D_SZH:0];
					q_nxt.chain = i_mem_rdata[`ERD_D_CHAIN];
					q_nxt.eor = i_mem_rdata[`ERD_D_EOR];
					q_nxt = issue(q_nxt, 1'b0, q_r.cur + `ERD_W2, 32'h0000_0000);
					q_nxt.st = ST_RD2;
				end
			end
			ST_RD2:
			begin
				if (ack)
				begin
					q_nxt.bufa = i_mem_rdata; // R6
					q_nxt = issue(q_nxt, 1'b0, q_r.cur + `ERD_W3, 32'h0000_0000);
					q_nxt.st = ST_RD3;
				end
			end
			ST_RD3:
			begin
				if (ack)
				begin
					q_nxt.nxt_d = desc_next(q_r.cur, q_r.chain, q_r.eor, i_mem_rdata, ctl.base);
					q_nxt.off = 13'h0000;
					q_nxt.fs = !q_r.mid; // R14
					q_nxt.by_frame = 1'b0;
					q_nxt.st = q_r.mid ? ST_XFER : ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (!ctl.start)
					q_nxt.st = ST_IDLE;
				else if (i_fifo_level >= ctl.thr || i_fifo_frames != 8'h00) // R13
					q_nxt.st = ST_XFER;
			end
			ST_XFER:
			begin
				if (!q_r.req && !q_r.pop && i_fifo_valid)
				begin
					q_nxt = issue(q_nxt, 1'b1, q_r.bufa + {19'h00000, q_r.off}, i_fifo_data); // R6
					q_nxt.cur_eof = i_fifo_eof;
					q_nxt.lastb = inc;
					q_nxt.mid = 1'b1;
				end
				else if (ack)
				begin
					q_nxt.pop = 1'b1;
					q_nxt.off = off_n;
					q_nxt.flen = q_r.flen + 14'(q_r.lastb); // R24
					if (q_r.cur_eof || off_n + 13'(`ERD_WORD) > q_r.size)
					begin
						q_nxt.eof_seen = q_r.cur_eof;
						q_nxt = issue(q_nxt, 1'b0, q_r.nxt_d, 32'h0000_0000); // R6 R12
						q_nxt.st = ST_PEEK;
					end
				end
			end
			ST_PEEK:
			begin
				if (ack)
				begin
					q_nxt.w0 = i_mem_rdata; // R25
					if (q_r.eof_seen && ctl.tsen)
					begin
						q_nxt = issue(q_nxt, 1'b1, q_r.cur + `ERD_W2, i_rx_stamp[31:0]); // R9
						q_nxt.st = ST_TS2;
					end
					else
					begin
						// Close without stamps: last segment at frame end or when flushed, error only on a mid-frame flush
						q_nxt = issue(q_nxt, 1'b1, q_r.cur, close_word(q_r.flen, q_r.fs,
							q_r.eof_seen || (!i_mem_rdata[`ERD_D_OWN] && !ctl.dflush),
							!q_r.eof_seen && !i_mem_rdata[`ERD_D_OWN] && !ctl.dflush)); // R7 R8 R14 R15
						q_nxt.st = ST_CLOSE;
					end
				end
			end
			ST_TS2:
			begin
				if (ack)
				begin
					q_nxt = issue(q_nxt, 1'b1, q_r.cur + `ERD_W3, i_rx_stamp[63:32]); // R9
					q_nxt.st = ST_TS3;
				end
			end
			ST_TS3:
			begin
				if (ack)
				begin
					q_nxt = issue(q_nxt, 1'b1, q_r.cur, close_word(q_r.flen, q_r.fs, 1'b1, 1'b0)); // R9 R16
					q_nxt.st = ST_CLOSE;
				end
			end
			ST_CLOSE:
			begin
				if (ack)
				begin
					q_nxt.ev_rxi = q_r.eof_seen; // R16
					q_nxt.cur = q_r.nxt_d; // R18
					if (q_r.eof_seen)
					begin
						q_nxt.mid = 1'b0;
						q_nxt.flen = 14'h0000;
						q_nxt.eof_seen = 1'b0;
					end
					if (q_r.w0[`ERD_D_OWN])
					begin
						q_nxt = issue(q_nxt, 1'b0, q_r.nxt_d + `ERD_W1, 32'h0000_0000); // R8 R10
						q_nxt.st = ST_RD1;
					end
					else
					begin
						q_nxt.ev_rbu = 1'b1; // R10 R17
						q_nxt.st = ST_SUSP;
						if (!q_r.eof_seen && !ctl.dflush)
						begin
							q_nxt.drop = 1'b1; // R10
							q_nxt.mid = 1'b0;
							q_nxt.flen = 14'h0000;
						end
					end
				end
			end
			ST_SUSP:
			begin
				if (!ctl.start)
					q_nxt.st = ST_IDLE;
				else if (ctl.poll || sof_new)
				begin
					q_nxt.by_frame = sof_new && !ctl.poll;
					q_nxt = issue(q_nxt, 1'b0, q_r.cur, 32'h0000_0000); // R11 R12 R18 R19
					q_nxt.st = ST_RD0;
				end
			end
			ST_DROP:
			begin
				// Wait until the FIFO has seen the discard before looking again
				if (!q_r.drop)
				begin
					if (i_fifo_frames != 8'h00)
					begin
						q_nxt.by_frame = 1'b1;
						q_nxt = issue(q_nxt, 1'b0, q_r.cur, 32'h0000_0000); // R20
						q_nxt.st = ST_RD0;
					end
					else
						q_nxt.st = ST_SUSP;
				end
			end
			default: q_nxt.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			q_r <= '{st: ST_IDLE, default: '0};
		else
			q_r <= q_nxt;
	end

	assign o_mem_req = q_r.req;
	assign o_mem_we = q_r.we;
	assign o_mem_addr = q_r.addr;
	assign o_mem_wdata = q_r.wdata;
	assign o_fifo_pop = q_r.pop;
	assign o_fifo_drop = q_r.drop;
	assign ctl.ev_rxi = q_r.ev_rxi;
	assign ctl.ev_rbu = q_r.ev_rbu;
	assign ctl.miss = q_r.miss;
	assign ctl.cur = q_r.cur;

	// ==========================================
	// Checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	property p_start;
		(q_r.st == ST_IDLE && ctl.start) |=> (q_r.st == ST_RD0 && q_r.req && q_r.addr == $past(ctl.base));
	endproperty
	a_start: assert property (p_start) else $error("run entry did not fetch base"); // R4
	property p_susp_rbu;
		($rose(q_r.st == ST_SUSP) && $past(q_r.st) != ST_DROP) |-> q_r.ev_rbu;
	endproperty
	a_susp_rbu: assert property (p_susp_rbu) else $error("suspend without buffer unavailable"); // R17
	property p_thr;
		(q_r.st == ST_WAIT ##1 q_r.st == ST_XFER) |-> ($past(i_fifo_level) >= $past(ctl.thr)
			|| $past(i_fifo_frames) != 8'h00);
	endproperty
	a_thr: assert property (p_thr) else $error("transfer began below threshold"); // R13
	property p_close;
		(q_r.req && q_r.we && q_r.addr == q_r.cur) |-> !q_r.wdata[`ERD_D_OWN];
	endproperty
	a_close: assert property (p_close) else $error("descriptor closed with ownership kept"); // R15
	property p_rxi;
		q_r.ev_rxi |-> ($past(q_r.st) == ST_CLOSE && $past(i_mem_ack) && $past(q_r.eof_seen));
	endproperty
	a_rxi: assert property (p_rxi) else $error("receive status not after frame close"); // R16
	property p_miss;
		(q_r.drop && $past(q_r.st) == ST_RD0) |-> q_r.miss == $past(q_r.miss) + 16'h0001;
	endproperty
	a_miss: assert property (p_miss) else $error("missed count not bumped"); // R20
	property p_disable_flush_control;
		(q_r.st == ST_RD0 && ack && !i_mem_rdata[`ERD_D_OWN] && ctl.dflush) |=> (!q_r.drop && q_r.st == ST_SUSP);
	endproperty
	a_disable_flush_control: assert property (p_disable_flush_control) else $error("frame discarded with flush disabled"); // R21
	property p_ls;
		(q_r.st == ST_CLOSE && q_r.req && q_r.eof_seen) |-> q_r.wdata[`ERD_D_LS];
	endproperty
	a_ls: assert property (p_ls) else $error("frame end closed without last segment"); // R16

	c_frame: cover property (q_r.ev_rxi);
	c_susp: cover property (q_r.st == ST_SUSP ##[1:50] q_r.st == ST_RD1);
	c_drop: cover property (q_r.drop && q_r.st == ST_DROP);
	c_inter: cover property (q_r.st == ST_CLOSE && ack && !q_r.eof_seen && q_r.w0[`ERD_D_OWN]);
endmodule

// ### sim/erd_mem_model.sv
// Word memory answering the engine's memory master
// ==========================================
module erd_mem_model #(
	parameter int DLY = 1
)
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	output logic o_ack,
	output logic [31:0] o_rdata,
	output int o_bad
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [0:1023];
	int wait_n;
	always @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_ack <= 1'b0;
			o_rdata <= 32'h0000_0000;
			wait_n <= 0;
			o_bad <= 0;
		end
		else if (i_req && !o_ack && wait_n >= DLY)
		begin
			o_ack <= 1'b1;
			wait_n <= 0;
			if (i_we)
			begin
				// Word0 of a descriptor area may be written only while DMA-owned
				if (i_addr < 32'h0000_0200 && i_addr[3:2] == 2'h0 && !mem[i_addr[11:2]][31])
					o_bad <= o_bad + 1;
				mem[i_addr[11:2]] <= i_wdata;
			end
			else
				o_rdata <= mem[i_addr[11:2]];
		end
		else
		begin
			// Released data lines show a changing pattern
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			wait_n <= (i_req && !o_ack) ? wait_n + 1 : 0;
		end
	end
endmodule

// ### sim/erd_top_tb.sv
// Self-checking bench of the receive descriptor engine
// ==========================================
`include "erd_cfg.svh"
module erd_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import erd_pkg::*;
	logic i_ref_clk = 1'b0, i_nrst = 1'b0;
	logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic [4:0] i_wb_adr = 5'h00;
	logic [31:0] i_wb_dat = 32'h0000_0000, o_wb_dat;
	logic o_wb_ack, o_mem_req, o_mem_we, i_mem_ack, o_fifo_pop, o_fifo_drop;
	logic [31:0] o_mem_addr, o_mem_wdata, i_mem_rdata, i_fifo_data;
	logic [11:0] i_fifo_level;
	logic [7:0] i_fifo_frames;
	logic i_fifo_valid, i_fifo_sof, i_fifo_eof;
	logic i_tx_own = 1'b0, i_tx_chain = 1'b0, i_tx_done = 1'b0, i_tx_stamp_req = 1'b0, i_tx_last = 1'b0;
	logic [31:0] i_tx_word3 = 32'h0000_0000, i_tx_stamp_hi = 32'h0000_0000;
	logic [31:0] o_tx_buf2_addr, o_tx_next_desc, o_tx_w3_data, q;
	logic o_tx_w3_wr;
	logic [31:0] fw [0:2] = '{32'h1122_3344, 32'h5566_7788, 32'h99AA_BBCC};
	int fidx = 0, fn = 0, frm = 0, pops = 0, drops = 0, mem_bad, failures = 0, compares = 0, n;
	assign i_fifo_valid = fidx < fn;
	assign i_fifo_data = i_fifo_valid ? fw[fidx] : ~fw[0];
	assign i_fifo_sof = i_fifo_valid && fidx == 0;
	assign i_fifo_eof = i_fifo_valid && fidx == fn - 1;
	assign i_fifo_level = 12'((fn - fidx) * 4);
	assign i_fifo_frames = 8'(frm);
	initial
	begin
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	erd_top dut_u (.i_ref_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
		.i_wb_sel(4'hF), .o_wb_dat, .o_wb_ack, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata,
		.i_mem_ack, .i_mem_rdata, .i_fifo_level, .i_fifo_frames, .i_fifo_valid, .i_fifo_data,
		.i_fifo_sof, .i_fifo_eof, .i_fifo_bytes(3'h2), .o_fifo_pop, .o_fifo_drop,
		.i_rx_stamp(64'h0123_4567_89AB_CDEF), .i_tx_own, .i_tx_chain, .i_tx_word3, .i_tx_done,
		.i_tx_stamp_req, .i_tx_last, .i_tx_stamp_hi, .o_tx_buf2_addr, .o_tx_next_desc,
		.o_tx_w3_wr, .o_tx_w3_data);
	erd_mem_model #(.DLY(1)) mem_u (.i_ref_clk, .i_nrst, .i_req(o_mem_req), .i_we(o_mem_we),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata), .o_bad(mem_bad));
	// ==========================================
	// Receive FIFO head, advanced by pop and emptied by drop
	always @(posedge i_ref_clk)
	begin
		if (o_fifo_pop)
		begin
			fidx <= fidx + 1;
			pops <= pops + 1;
		end
		if (o_fifo_drop)
		begin
			fidx <= fn;
			frm <= 0;
			drops <= drops + 1;
		end
	end
	// ==========================================
	// Tasks
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wb(input logic we, input logic [4:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= a;
		i_wb_dat <= d;
		do
			@(posedge i_ref_clk);
		while (o_wb_ack !== 1'b1);
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask
	task rd(input string name, input logic [4:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		chk(name, q, exp);
	endtask
	task tx(input logic own, input logic chain, input logic done, input logic last);
		@(posedge i_ref_clk);
		i_tx_own <= own;
		i_tx_chain <= chain;
		i_tx_word3 <= 32'h0000_0A40;
		i_tx_stamp_hi <= 32'h5A5A_0001;
		i_tx_stamp_req <= 1'b1;
		i_tx_last <= last;
		i_tx_done <= done;
		@(posedge i_ref_clk);
		i_tx_done <= 1'b0;
		@(negedge i_ref_clk);
	endtask
	task report_and_stop;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================
	// Tests
	initial
	begin
		repeat (20000) @(posedge i_ref_clk);
		failures++;
		report_and_stop;
	end
	initial
	begin
		for (int i = 0; i < 1024; i++)
			mem_u.mem[i] = 32'h0000_0000;
		mem_u.mem[10'h040] = 32'h8000_0000;
		mem_u.mem[10'h041] = 32'h0000_0040;
		mem_u.mem[10'h042] = 32'h0000_0400;
		repeat (4) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		rd("thr", `ERD_A_THR, 32'h0000_0040);
		rd("opm", `ERD_A_OPM, 32'h0000_0000);
		rd("unmapped", 5'h1C, 32'h0000_0000);
		$display("test registers done");
		wb(1'b1, `ERD_A_BASE, 32'h0000_0100);
		wb(1'b1, `ERD_A_OPM, 32'h0000_0002);
		@(posedge i_ref_clk);
		fidx <= 0;
		fn <= 3;
		repeat (30) @(posedge i_ref_clk);
		chk("pops below threshold", 32'(pops), 32'h0000_0000);
		wb(1'b1, `ERD_A_THR, 32'h0000_0008);
		n = 0;
		while (mem_u.mem[10'h040][31] !== 1'b0 && n < 500)
		begin
			@(posedge i_ref_clk);
			n++;
		end
		repeat (20) @(posedge i_ref_clk);
		for (int i = 0; i < 3; i++)
			chk("buffer word", mem_u.mem[10'h100 + i], fw[i]);
		chk("desc0 word0", mem_u.mem[10'h040], 32'h000A_0300);
		rd("status", `ERD_A_STS, 32'h0000_00C0);
		rd("current", `ERD_A_CUR, 32'h0000_0110);
		wb(1'b1, `ERD_A_STS, 32'h0000_00C0);
		rd("status cleared", `ERD_A_STS, 32'h0000_0000);
		$display("test frame done");
		@(posedge i_ref_clk);
		fidx <= 0;
		frm <= 1;
		n = 0;
		while (drops == 0 && n < 500)
		begin
			@(posedge i_ref_clk);
			n++;
		end
		repeat (20) @(posedge i_ref_clk);
		chk("drops", 32'(drops), 32'h0000_0001);
		rd("missed", `ERD_A_MISS, 32'h0000_0001);
		chk("owned writes", 32'(mem_bad), 32'h0000_0000);
		$display("test suspend done");
		mem_u.mem[10'h044] = 32'h8000_0000;
		mem_u.mem[10'h045] = 32'h0000_0008;
		mem_u.mem[10'h046] = 32'h0000_0500;
		mem_u.mem[10'h048] = 32'h8000_0000;
		mem_u.mem[10'h049] = 32'h0000_0040;
		mem_u.mem[10'h04A] = 32'h0000_0600;
		wb(1'b1, `ERD_A_OPM, 32'h0000_0006);
		wb(1'b1, `ERD_A_POLL, 32'h0000_0001);
		@(posedge i_ref_clk);
		fidx <= 0;
		n = 0;
		while (mem_u.mem[10'h048][31] !== 1'b0 && n < 500)
		begin
			@(posedge i_ref_clk);
			n++;
		end
		repeat (20) @(posedge i_ref_clk);
		chk("seg1 word a", mem_u.mem[10'h140], fw[0]);
		chk("seg1 word b", mem_u.mem[10'h141], fw[1]);
		chk("seg2 word", mem_u.mem[10'h180], fw[2]);
		chk("seg1 word0", mem_u.mem[10'h044], 32'h0008_0200);
		chk("seg2 word0", mem_u.mem[10'h048], 32'h000A_0100);
		chk("stamp low", mem_u.mem[10'h04A], 32'h89AB_CDEF);
		chk("stamp high", mem_u.mem[10'h04B], 32'h0123_4567);
		rd("status two", `ERD_A_STS, 32'h0000_00C0);
		wb(1'b1, `ERD_A_STS, 32'h0000_00C0);
		$display("test segments done");
		wb(1'b1, `ERD_A_OPM, 32'h0100_0006);
		@(posedge i_ref_clk);
		fidx <= 0;
		frm <= 1;
		repeat (40) @(posedge i_ref_clk);
		chk("kept frame", 32'(drops), 32'h0000_0001);
		rd("status kept", `ERD_A_STS, 32'h0000_0080);
		$display("test flush off done");
		tx(1'b1, 1'b0, 1'b0, 1'b0);
		chk("buf2", o_tx_buf2_addr, 32'h0000_0A40);
		tx(1'b1, 1'b1, 1'b1, 1'b1);
		chk("next", o_tx_next_desc, 32'h0000_0A40);
		chk("w3 wr", 32'(o_tx_w3_wr), 32'h0000_0001);
		chk("w3 data", o_tx_w3_data, 32'h5A5A_0001);
		tx(1'b1, 1'b1, 1'b1, 1'b0);
		chk("w3 no wr", 32'(o_tx_w3_wr), 32'h0000_0000);
		$display("test tx word3 done");
		report_and_stop;
	end
endmodule
